// *** rtl/abce_pkg.sv ***
// Purpose: Shared constants for the AND, bit clear and conditional branch executor.
// Assumes: Byte addresses on the register bus, 32-bit data, one aligned word per register.
// Notes: Flag bit positions follow the status byte layout used by the core.
package abce_pkg;

   // Phases of one instruction cycle, one aclk period each while running.
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} abce_phase_e;

   // Register byte offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_FLAGS = 8'h08;
   localparam logic [7:0] REG_BANK = 8'h0c;
   localparam logic [7:0] REG_INDEX = 8'h10;
   localparam logic [7:0] REG_PC = 8'h14;
   localparam logic [7:0] REG_INFO = 8'h18;

   // Control bits and status flag positions.
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXT = 1;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;

   // Reset values.
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [11:0] INDEX_RESET = 12'h000;
   localparam logic [20:0] PC_RESET = 21'h000000;

   // Opcode fields.
   localparam logic [5:0] OP_AND = 6'h05;
   localparam logic [3:0] OP_BCLR = 4'h9;
   localparam logic [4:0] OP_BRANCH = 5'h1c;
   localparam logic [2:0] BR_ZERO_CLEAR = 3'h1;
   localparam logic [2:0] BR_CARRY_SET = 3'h2;
   localparam logic [2:0] BR_CARRY_CLEAR = 3'h3;
   localparam logic [2:0] BR_OVERFLOW_CLEAR = 3'h5;
   localparam logic [2:0] BR_NEGATIVE_SET = 3'h6;
   localparam logic [2:0] BR_NEGATIVE_CLEAR = 3'h7;

   // Addressing constants.
   localparam logic [7:0] INDEX_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   localparam logic [20:0] PC_STEP = 21'h000002;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : abce_pkg

// *** rtl/abce_phase.sv ***
// Purpose: Four-phase sequencer for the instruction cycle.
// Assumes: One clock; run gates every phase step.
// Notes: adv is the one-cycle enable that moves the core to the next phase.
`timescale 1ns/1ns
module abce_phase
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   output abce_pkg::abce_phase_e phase,
   output logic adv
);

   abce_pkg::abce_phase_e next_phase;

   // The step enable follows run directly so a halt freezes the phase.
   assign adv = run;

   // Next phase wraps from the fourth phase back to the first.
   always_comb
   begin
      unique case (phase)
         abce_pkg::PH_Q1: next_phase = abce_pkg::PH_Q2;
         abce_pkg::PH_Q2: next_phase = abce_pkg::PH_Q3;
         abce_pkg::PH_Q3: next_phase = abce_pkg::PH_Q4;
         abce_pkg::PH_Q4: next_phase = abce_pkg::PH_Q1;
      endcase
   end

   // Phase register.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         phase <= abce_pkg::PH_Q1;
      else if (adv)
         phase <= next_phase;
   end

endmodule : abce_phase

// *** rtl/abce_exec.sv ***
// Purpose: Executes AND with file, bit clear in file and six conditional relative branches.
// Assumes: Data memory reads are synchronous: data for an enable in Q2 is valid in Q3.
// Notes: Registers over AXI4-Lite; the core steps only while the run bit is set.
// How it works
// RULE1: AND opcode 0001 01da with file address; updates only negative and zero.
// RULE2: AND result goes to accumulator when d is 0, else to file.
// RULE3: Access bit 0 selects access bank; 1 uses bank select register.
// RULE4: Extended set with access bit 0 indexes addresses up to 95.
// RULE5: Opcode 1110 0010 branches when carry set; flags unchanged.
// RULE6: Opcode 1110 0110 branches when negative set; flags unchanged.
// RULE7: Opcode 1110 0011 branches when carry clear; flags unchanged.
// RULE8: Opcode 1110 0111 branches when negative clear; flags unchanged.
// RULE9: Opcode 1110 0101 branches when overflow clear; flags unchanged.
// RULE10: Opcode 1110 0001 branches when zero clear; flags unchanged.
// RULE11: Taken branch loads incremented counter plus twice the signed offset.
// RULE12: Untaken branch takes one cycle; taken adds one all-idle cycle.
// RULE13: Pattern 1001 bbba clears bit b of the file; flags unaffected.
// RULE14: AND and bit clear read in Q2, process in Q3, write Q4.
// RULE15: Untaken branch advances counter sequentially and writes nothing in Q4.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module abce_exec
#(
   parameter int ADDR_W = 8,
   parameter int PC_W = 21
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   output logic instr_ready,
   output logic [PC_W-1:0] pc,
   output logic [11:0] dmem_addr,
   output logic dmem_rd_en,
   input wire logic [7:0] dmem_rdata,
   output logic dmem_wr_en,
   output logic [7:0] dmem_wdata
);

   abce_pkg::abce_phase_e phase;
   logic adv;
   logic [1:0] ctrl;
   logic [7:0] acc;
   logic [4:0] flags;
   logic [3:0] bank_select_register;
   logic [11:0] index_base;
   logic [15:0] ir;
   logic ir_valid;
   logic nop_cycle;
   logic [7:0] res;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // Merges a bus write into an old register value under the byte strobes.
   function automatic logic [31:0] abce_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] v;
      v = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            v[8*i +: 8] = new_v[8*i +: 8];
      return v;
   endfunction : abce_merge

   abce_phase u_phase
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(ctrl[abce_pkg::CTRL_RUN]),
      .phase(phase),
      .adv(adv)
   );

   // Phase strobes and instruction field decode.
   wire q1_end = adv && phase == abce_pkg::PH_Q1;
   wire q3_end = adv && phase == abce_pkg::PH_Q3;
   wire q4_end = adv && phase == abce_pkg::PH_Q4;
   wire take = q4_end && instr_ready && instr_valid;
   wire is_and = ir[15:10] == abce_pkg::OP_AND;
   wire is_bclr = ir[15:12] == abce_pkg::OP_BCLR;
   wire is_br = ir[15:11] == abce_pkg::OP_BRANCH;
   wire dest_file = ir[9];
   wire acc_bit = ir[8];
   wire [7:0] f_addr = ir[7:0];
   wire [2:0] bit_pos = ir[11:9];
   wire [7:0] bit_mask = 8'h01 << bit_pos;
   wire uses_file = is_and || is_bclr;
   wire writes_file = (is_and && dest_file) || is_bclr;

   // Branch condition evaluation; other condition codes are not handled here.
   wire flag_c = flags[abce_pkg::FLAG_C];
   wire flag_z = flags[abce_pkg::FLAG_Z];
   wire flag_ov = flags[abce_pkg::FLAG_OV];
   wire flag_n = flags[abce_pkg::FLAG_N];
   wire cond_ok = (ir[10:8] == abce_pkg::BR_CARRY_SET && flag_c)      // RULE5
      || (ir[10:8] == abce_pkg::BR_NEGATIVE_SET && flag_n)            // RULE6
      || (ir[10:8] == abce_pkg::BR_CARRY_CLEAR && !flag_c)            // RULE7
      || (ir[10:8] == abce_pkg::BR_NEGATIVE_CLEAR && !flag_n)         // RULE8
      || (ir[10:8] == abce_pkg::BR_OVERFLOW_CLEAR && !flag_ov)        // RULE9
      || (ir[10:8] == abce_pkg::BR_ZERO_CLEAR && !flag_z);            // RULE10
   wire br_hit = ir_valid && is_br && cond_ok;
   wire [PC_W-1:0] br_disp = PC_W'({{(PC_W-9){ir[7]}}, ir[7:0], 1'b0}); // RULE11

   // File address: access bank, bank select register, or indexed literal offset.
   wire indexed = !acc_bit && ctrl[abce_pkg::CTRL_EXT] && f_addr <= abce_pkg::INDEX_LIMIT; // RULE4
   wire [11:0] idx_addr = index_base + {4'h0, f_addr};
   wire [3:0] acc_bank = (f_addr >= abce_pkg::ACCESS_SPLIT) ? abce_pkg::ACCESS_HIGH_BANK
                                                            : abce_pkg::ACCESS_LOW_BANK;
   wire [11:0] file_addr = indexed ? idx_addr
                         : acc_bit ? {bank_select_register, f_addr}      // RULE3
                         : {acc_bank, f_addr};                         // RULE3
   wire [7:0] next_res = is_and ? (acc & dmem_rdata) : (dmem_rdata & ~bit_mask); // RULE1 RULE13

   // Bus decode and handshakes.
   wire aw_acc = awvalid && awready;
   wire w_acc = wvalid && wready;
   wire ar_acc = arvalid && arready;
   wire do_write = aw_held && w_held && !bvalid;
   wire next_aw_held = (aw_held || aw_acc) && !do_write;
   wire next_w_held = (w_held || w_acc) && !do_write;
   wire next_bvalid = do_write || (bvalid && !bready);
   wire next_rvalid = ar_acc || (rvalid && !rready);
   wire [7:0] wr_off = 8'({aw_addr_q[ADDR_W-1:2], 2'b00});
   wire [7:0] rd_off = 8'({araddr[ADDR_W-1:2], 2'b00});
   wire wr_ctrl = do_write && wr_off == abce_pkg::REG_CTRL;
   wire wr_acc = do_write && wr_off == abce_pkg::REG_ACC;
   wire wr_flags = do_write && wr_off == abce_pkg::REG_FLAGS;
   wire wr_bank = do_write && wr_off == abce_pkg::REG_BANK;
   wire wr_index = do_write && wr_off == abce_pkg::REG_INDEX;
   wire wr_pc = do_write && wr_off == abce_pkg::REG_PC;
   wire wr_known = wr_off == abce_pkg::REG_CTRL || wr_off == abce_pkg::REG_ACC
      || wr_off == abce_pkg::REG_FLAGS || wr_off == abce_pkg::REG_BANK
      || wr_off == abce_pkg::REG_INDEX || wr_off == abce_pkg::REG_PC;
   wire [31:0] wr_merged = abce_merge(32'h00000000, wdata_q, wstrb_q);
   wire [31:0] index_merged = abce_merge({20'h0, index_base}, wdata_q, wstrb_q);
   wire wr_known_rd = rd_off == abce_pkg::REG_CTRL || rd_off == abce_pkg::REG_ACC
      || rd_off == abce_pkg::REG_FLAGS || rd_off == abce_pkg::REG_BANK
      || rd_off == abce_pkg::REG_INDEX || rd_off == abce_pkg::REG_PC;
   wire rd_known = wr_known_rd || rd_off == abce_pkg::REG_INFO;
   wire [31:0] rd_word =
        rd_off == abce_pkg::REG_CTRL ? {30'h0, ctrl}
      : rd_off == abce_pkg::REG_ACC ? {24'h0, acc}
      : rd_off == abce_pkg::REG_FLAGS ? {27'h0, flags}
      : rd_off == abce_pkg::REG_BANK ? {28'h0, bank_select_register}
      : rd_off == abce_pkg::REG_INDEX ? {20'h0, index_base}
      : rd_off == abce_pkg::REG_PC ? 32'(pc)
      : rd_off == abce_pkg::REG_INFO ? {12'h0, ir_valid, nop_cycle, phase, ir}
      : 32'h00000000;

   // Write channel capture and response.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= abce_pkg::RESP_OKAY;
         aw_addr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awready <= !next_aw_held && !next_bvalid;
         wready <= !next_w_held && !next_bvalid;
         bvalid <= next_bvalid;
         if (aw_acc)
            aw_addr_q <= awaddr;
         if (w_acc)
         begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_write)
            bresp <= wr_known ? abce_pkg::RESP_OKAY : abce_pkg::RESP_SLVERR;
      end
   end

   // Read channel: one read outstanding, unmapped offsets read zero with an error.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= abce_pkg::RESP_OKAY;
      end
      else
      begin
         arready <= !next_rvalid;
         rvalid <= next_rvalid;
         if (ar_acc)
         begin
            rdata <= rd_word;
            rresp <= rd_known ? abce_pkg::RESP_OKAY : abce_pkg::RESP_SLVERR;
         end
      end
   end

   // Software-only configuration registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= abce_pkg::CTRL_RESET;
         bank_select_register <= abce_pkg::BANK_RESET;
         index_base <= abce_pkg::INDEX_RESET;
      end
      else
      begin
         if (wr_ctrl && wstrb_q[0])
            ctrl <= wr_merged[1:0];
         if (wr_bank && wstrb_q[0])
            bank_select_register <= wr_merged[3:0];
         if (wr_index)
            index_base <= index_merged[11:0];
      end
   end

   // Accumulator and flags; the executing instruction wins over a bus write.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc <= abce_pkg::ACC_RESET;
         flags <= abce_pkg::FLAGS_RESET;
      end
      else
      begin
         if (q4_end && ir_valid && is_and && !dest_file)
            acc <= res;                                   // RULE2
         else if (wr_acc && wstrb_q[0])
            acc <= wr_merged[7:0];
         if (q4_end && ir_valid && is_and)
         begin
            flags[abce_pkg::FLAG_N] <= res[7];            // RULE1
            flags[abce_pkg::FLAG_Z] <= res == 8'h00;      // RULE1
         end
         else if (wr_flags && wstrb_q[0])
            flags <= wr_merged[4:0];
      end
   end

   // Program counter: step on fetch, relative load on a taken branch.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pc <= PC_W'(abce_pkg::PC_RESET);
      else if (q4_end && br_hit)
         pc <= pc + br_disp;                              // RULE11
      else if (take)
         pc <= pc + PC_W'(abce_pkg::PC_STEP);             // RULE15
      else if (wr_pc)
         pc <= PC_W'(abce_merge(32'(pc), wdata_q, wstrb_q));
   end

   // Phase sequence: decode Q1, read Q2, process Q3, write Q4.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ir <= 16'h0000;
         ir_valid <= 1'b0;
         nop_cycle <= 1'b0;
         instr_ready <= 1'b0;
         res <= 8'h00;
         dmem_addr <= 12'h000;
         dmem_rd_en <= 1'b0;
         dmem_wr_en <= 1'b0;
         dmem_wdata <= 8'h00;
      end
      else if (adv)
      begin
         unique case (phase)
            abce_pkg::PH_Q1:
            begin
               dmem_rd_en <= ir_valid && uses_file;       // RULE14
               dmem_addr <= file_addr;
            end
            abce_pkg::PH_Q2:
               dmem_rd_en <= 1'b0;
            abce_pkg::PH_Q3:
            begin
               res <= next_res;                           // RULE14
               dmem_wr_en <= ir_valid && writes_file;     // RULE2 RULE13 RULE15
               dmem_wdata <= next_res;
               instr_ready <= !br_hit;                    // RULE12
            end
            abce_pkg::PH_Q4:
            begin
               dmem_wr_en <= 1'b0;
               instr_ready <= 1'b0;
               ir_valid <= take;
               nop_cycle <= br_hit;                       // RULE12
               if (take)
                  ir <= instr_word;
            end
         endcase
      end
   end

   a_and_flags: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
      q4_end && ir_valid && is_and |=> flag_n == $past(res[7]) && flag_z == ($past(res) == 8'h00)
      && flag_c == $past(flag_c) && flag_ov == $past(flag_ov))
      else $error("AND flag update wrong.");
   a_and_acc_dest: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      q4_end && ir_valid && is_and && !dest_file |=> acc == $past(res) && !dmem_wr_en)
      else $error("AND result not placed in accumulator.");
   a_and_file_dest: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      q3_end && ir_valid && is_and && dest_file |=> dmem_wr_en && dmem_addr == $past(file_addr))
      else $error("AND result not written to file.");
   a_bank_select: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
      q1_end && ir_valid && uses_file && acc_bit |=> dmem_rd_en
      && dmem_addr == {bank_select_register, $past(f_addr)})
      else $error("Banked address wrong.");
   a_indexed_mode: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      q1_end && ir_valid && uses_file && indexed |=> dmem_addr == $past(idx_addr))
      else $error("Indexed address wrong.");
   a_branch_flags: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      q4_end && ir_valid && is_br |=> $stable(flags))
      else $error("Branch changed a flag.");
   a_branch_target: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
      q4_end && br_hit |=> pc == $past(pc) + $past(br_disp))
      else $error("Branch target wrong.");
   a_taken_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
      q4_end && br_hit |=> nop_cycle && !ir_valid && !instr_ready ##1 !dmem_rd_en && !dmem_wr_en)
      else $error("Taken branch cycle not idle.");
   a_untaken_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RULE15
      ir_valid && is_br && phase == abce_pkg::PH_Q4 |-> !dmem_wr_en)
      else $error("Branch wrote data memory.");
   a_clear_bit: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
      q3_end && ir_valid && is_bclr |=> dmem_wr_en
      && dmem_wdata == ($past(dmem_rdata) & ~(8'h01 << $past(bit_pos))))
      else $error("Bit clear data wrong.");

endmodule : abce_exec

// *** tb/abce_partner.sv ***
// Purpose: Model of the fetch path and the banked data memory beside the executor.
// Assumes: Memory reads are synchronous; read data is valid only in the phase after the enable.
// Notes: The bench loads prog and mem by hierarchy and may set hold to withhold words.
`timescale 1ns/1ns
module abce_partner
(
   input wire logic aclk,
   input wire logic [20:0] pc,
   output logic [15:0] instr_word,
   output logic instr_valid,
   input wire logic [11:0] dmem_addr,
   input wire logic dmem_rd_en,
   output logic [7:0] dmem_rdata,
   input wire logic dmem_wr_en,
   input wire logic [7:0] dmem_wdata
);
   logic [15:0] prog [0:511];
   logic [7:0] mem [0:4095];
   logic hold;
   logic [7:0] rd_q;
   logic rd_live;

   // Empty program words decode as no-ops; memory starts cleared.
   initial
   begin
      hold = 1'b0;
      rd_q = 8'h00;
      rd_live = 1'b0;
      for (int i = 0; i < 512; i++) prog[i] = 16'h0000;
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
   end

   // A withheld word shows a scrambled pattern so that nothing can pass by luck.
   assign instr_valid = !hold;
   assign instr_word = hold ? ~prog[pc[9:1]] : prog[pc[9:1]];

   // Read data is held one phase only, then shows the inverse of the last value.
   always @(posedge aclk)
   begin
      rd_live <= dmem_rd_en;
      if (dmem_rd_en) rd_q <= mem[dmem_addr];
      if (dmem_wr_en) mem[dmem_addr] <= dmem_wdata;
   end
   assign dmem_rdata = rd_live ? rd_q : ~rd_q;
endmodule : abce_partner

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the AND, bit clear and conditional branch executor.
// Assumes: Registers on AXI4-Lite; the partner model holds the program and the data memory.
// Notes: Programs end in a branch to itself; each halt is timed to land while pc rests on it.
`timescale 1ns/1ns
module tb_top;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, instr_valid, instr_ready;
   logic dmem_rd_en, dmem_wr_en;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] instr_word;
   logic [20:0] pc;
   logic [11:0] dmem_addr;
   logic [7:0] dmem_rdata, dmem_wdata;
   int failures;
   int n_checks;
   int cyc;
   int tk [0:15];

   // Free-running 50 MHz clock.
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   abce_exec #(.ADDR_W(8), .PC_W(21)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .instr_word(instr_word), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .pc(pc), .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en),
      .dmem_rdata(dmem_rdata), .dmem_wr_en(dmem_wr_en), .dmem_wdata(dmem_wdata));

   abce_partner pm (.aclk(aclk), .pc(pc), .instr_word(instr_word), .instr_valid(instr_valid),
      .dmem_addr(dmem_addr), .dmem_rd_en(dmem_rd_en), .dmem_rdata(dmem_rdata),
      .dmem_wr_en(dmem_wr_en), .dmem_wdata(dmem_wdata));

   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Write with address and data offered together, each released when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw_p || w_p)
      begin
         @(posedge aclk);
         aw_p = aw_p && !awready;
         w_p = w_p && !wready;
         awvalid <= aw_p;
         wvalid <= w_p;
      end
      do @(posedge aclk); while (!bvalid);
      chk("write resp", {30'h0, abce_pkg::RESP_OKAY}, {30'h0, bresp});
   endtask : wr

   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask : rdr

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
      rdr(a, rd, rs);
      chk(w, e, rd);
   endtask : rchk

   task automatic mchk(input logic [11:0] a, input logic [7:0] e);
      chk($sformatf("mem %h", a), {24'h0, e}, {24'h0, pm.mem[a]});
   endtask : mchk

   // Cycle count, start time of each early program word, and the hang limit.
   always @(posedge aclk)
   begin
      cyc = cyc + 1;
      if (instr_ready && instr_valid && pc[20:5] == 16'h0000) tk[pc[4:1]] = cyc;
      if (cyc == 20000)
      begin
         failures = failures + 1;
         close_out();
      end
   end

   // Main sequence: reset values, two programs, then the final state of each.
   initial
   begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      failures = 0;
      n_checks = 0;
      cyc = 0;
      for (int i = 0; i < 16; i++) tk[i] = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0, "reset value");
      rdr(8'h1c, rd, rs);
      chk("unmapped resp", {30'h0, abce_pkg::RESP_SLVERR}, {30'h0, rs});
      chk("unmapped data", 32'h0, rd);
      // Program one exercises the banked, indexed and upper access bank paths and all six branch conditions.
      pm.mem[12'h345] = 8'hc2;
      pm.mem[12'hf70] = 8'h70;
      pm.mem[12'h210] = 8'hc7;
      pm.mem[12'hf60] = 8'hff;
      pm.mem[12'h220] = 8'h82;
      pm.mem[12'h010] = 8'hff;
      pm.prog[0] = 16'h1545;
      pm.prog[1] = 16'h1670;
      pm.prog[2] = 16'he105;
      pm.prog[3] = 16'he201;
      pm.prog[4] = 16'he301;
      pm.prog[5] = 16'h1745;
      pm.prog[6] = 16'h9e10;
      pm.prog[7] = 16'h9060;
      pm.prog[8] = 16'he601;
      pm.prog[9] = 16'he701;
      pm.prog[10] = 16'h1745;
      pm.prog[11] = 16'h1420;
      pm.prog[12] = 16'he601;
      pm.prog[13] = 16'h1745;
      pm.prog[14] = 16'he101;
      pm.prog[15] = 16'h1745;
      pm.prog[16] = 16'he5ff;
      wr(abce_pkg::REG_ACC, 32'h97);
      wr(abce_pkg::REG_BANK, 32'h3);
      wr(abce_pkg::REG_INDEX, 32'h200);
      wr(abce_pkg::REG_CTRL, 32'h3);
      repeat (200) @(posedge aclk);
      wr(abce_pkg::REG_CTRL, 32'h2);
      rchk(abce_pkg::REG_PC, 32'h20, "pc");
      rchk(abce_pkg::REG_ACC, 32'h82, "acc");
      rchk(abce_pkg::REG_FLAGS, 32'h10, "flags");
      mchk(12'h345, 8'hc2);
      mchk(12'hf70, 8'h00);
      mchk(12'h210, 8'h47);
      mchk(12'hf60, 8'hfe);
      chk("untaken time", 32'd4, 32'(tk[3] - tk[2]));
      chk("taken time", 32'd8, 32'(tk[6] - tk[4]));
      chk("taken time n", 32'd8, 32'(tk[11] - tk[9]));
      chk("skipped word", 32'd0, 32'(tk[5]));
      // Program two: plain access bank, carry branch at the offset minimum, late words.
      pm.prog[9'h180] = 16'h9210;
      pm.prog[9'h181] = 16'he280;
      pm.prog[9'h102] = 16'he5ff;
      wr(abce_pkg::REG_FLAGS, 32'h1);
      wr(abce_pkg::REG_PC, 32'h300);
      pm.hold <= 1'b1;
      wr(abce_pkg::REG_CTRL, 32'h1);
      repeat (20) @(posedge aclk);
      rchk(abce_pkg::REG_PC, 32'h300, "pc held");
      pm.hold <= 1'b0;
      // The closing loop swaps pc between its word and the next; this wait stops it on the word.
      repeat (96) @(posedge aclk);
      wr(abce_pkg::REG_CTRL, 32'h0);
      rchk(abce_pkg::REG_PC, 32'h204, "pc min offset");
      rchk(abce_pkg::REG_FLAGS, 32'h1, "flags kept");
      mchk(12'h010, 8'hfd);
      mchk(12'h210, 8'h47);
      close_out();
   end
endmodule : tb_top
